// file: logic/mts_pkg.sv
// Types shared by the turn interface
package mts_pkg;
    // One-hot sequencer states
    typedef enum logic [6:0] {
        S_INIT  = 7'h01,
        S_START = 7'h02,
        S_FRAME = 7'h04,
        S_EVAL  = 7'h08,
        S_PAUSE = 7'h10,
        S_RUN   = 7'h20,
        S_DEAD  = 7'h40
    } mts_state_t;
endpackage

// file: logic/mts_regs.svh
// Register indices, field positions, reset values and timing of the turn interface
`ifndef MTS_REGS_SVH
`define MTS_REGS_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define MTS_IDX_LEN 8'h3E
`define MTS_IDX_SRC 8'h40
`define MTS_IDX_SYNC 8'h41
`define MTS_IDX_STAT 8'h50
`define MTS_IDX_MASK 8'h51
`define MTS_IDX_CMD 8'h52
`define MTS_IDX_COUNT 8'h53

// ****************************************
// Field positions and codes
// ****************************************
`define MTS_LEN_LO 4
`define MTS_SRC_LO 3
`define MTS_CHK_BIT 6
`define MTS_SBL_LO 0
`define MTS_LNT_BIT 2
`define MTS_GRAY_BIT 3
`define MTS_SRC_INT 2'h0
`define MTS_SRC_PAR 2'h3
`define MTS_SRC_SER 2'h2
`define MTS_CMD_SOFT 8'h01
`define MTS_ST_LINK 0
`define MTS_ST_CONS 1
`define MTS_ST_SYNC 2
`define MTS_REG_RST 8'h00
`define MTS_LAST_TRY 2'h3

// ****************************************
// Timing
// ****************************************
`define MTS_CLK_NS 10
`define MTS_CHECK_NS 8000000
`define MTS_RETRY_NS 128000
`define MTS_HALF_NS 40

`endif

// file: logic/mts_top.sv
// Multiturn interface: turn counter, serial and two-pin sector link, sync and check
// Contract
// RULE_01: after syncing the external word, load the turn counter then count revolutions
// RULE_02: an internal turn counter up to 24 bits works without any external link
// RULE_03: source field 0x40 bits 4:3: 00 internal, 10 serial link, 11 sector pins
// RULE_04: in sector mode the clock pin is a 180 degree input, data pin 90 degree
// RULE_05: the configuring party keeps the turn CRC disable setting at zero
// RULE_06: after changing the source field the controller issues the soft reset command
// RULE_07: one length setting sizes the counter and the external word, sync bits excluded
// RULE_08: length codes 0 to 12 give 8 to 20 bits, 13 is 24, 14 is 1, 15 is 4
// RULE_09: sync field 0x41 bits 1:0 selects 1 to 4 sync bits
// RULE_10: with more than one sync bit, align the external word automatically
// RULE_11: with one sync bit, the lead/trail bit says trailing (0) or leading (1)
// RULE_12: with two or more sync bits, the lead/trail bit is ignored
// RULE_13: with the check bit set, compare counter with external word every 8 ms
// RULE_14: a mismatch sets the consistency flag and the serial error bit
// RULE_15: format bit selects binary (0) or Gray (1) for the received word
// RULE_16: in sector mode the sector bit and its sync bit double the covered range
// RULE_17: startup read failures retry three times, 128 us apart, then flag permanently
// RULE_18: with checking on, a link error stops all readouts and flags permanently
// RULE_19: a Gray word is converted to binary before sync and comparison
`include "mts_regs.svh"

module mts_top #(
    parameter int CHECK_CYC = `MTS_CHECK_NS / `MTS_CLK_NS,
    parameter int RETRY_CYC = `MTS_RETRY_NS / `MTS_CLK_NS,
    parameter int MAX_LEN = 24
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Singleturn quadrant from the position logic
    input wire logic [1:0] ST_QUAD_I,
    // Turn link pins
    input wire logic TURN_LINK_CLOCK_PIN_I,
    output logic TURN_LINK_CLOCK_PIN_O,
    output logic TURN_LINK_CLOCK_PIN_OE_O,
    input wire logic TURN_LINK_DATA_PIN_I,
    // Turn result and alarms
    output logic [23:0] TURN_COUNT_O,
    output logic TURN_VALID_O,
    output logic ERR_N_O,
    output logic IRQ_O
);

    localparam int HALF_CYC = (`MTS_HALF_NS + `MTS_CLK_NS - 1) / `MTS_CLK_NS;

    // ****************************************
    // Functions
    // ****************************************

    // Word length from its code
    function automatic logic [4:0] len_decode(input logic [3:0] c);
        case (c)
            4'hD: len_decode = 5'h18;
            4'hE: len_decode = 5'h01;
            4'hF: len_decode = 5'h04;
            default: len_decode = 5'h08 + {1'b0, c};
        endcase
    endfunction

    // Mask of the low n bits
    function automatic logic [27:0] low_mask(input logic [4:0] n);
        low_mask = ~(28'hFFFFFFF << n);
    endfunction

    // Gray to binary by prefix xor
    function automatic logic [27:0] gray2bin(input logic [27:0] g);
        logic [27:0] b;
        b = g;
        for (int i = 26; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        gray2bin = b;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] clk_pin_sync_reg;
    logic [1:0] dat_pin_sync_reg;
    wire logic turn_link_clock_pin_s = clk_pin_sync_reg[1];
    wire logic turn_link_data_pin_s = dat_pin_sync_reg[1];

    // Two flops for each pin
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            clk_pin_sync_reg <= 2'h0;
            dat_pin_sync_reg <= 2'h0;
        end else begin
            clk_pin_sync_reg <= {clk_pin_sync_reg[0], TURN_LINK_CLOCK_PIN_I};
            dat_pin_sync_reg <= {dat_pin_sync_reg[0], TURN_LINK_DATA_PIN_I};
        end
    end

    // ****************************************
    // Registers and APB decode
    // ****************************************
    logic [7:0] len_reg;
    logic [7:0] src_reg;
    logic [7:0] sync_reg;
    logic [7:0] mask_reg;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [31:0] prdata_reg;
    logic [23:0] cnt_reg;

    wire logic [7:0] idx = PADDR_I[9:2];
    wire logic aligned = (PADDR_I[1:0] == 2'h0) && (PADDR_I[11:10] == 2'h0);
    wire logic hit_len = aligned && (idx == `MTS_IDX_LEN);
    wire logic hit_src = aligned && (idx == `MTS_IDX_SRC);
    wire logic hit_sync = aligned && (idx == `MTS_IDX_SYNC);
    wire logic hit_stat = aligned && (idx == `MTS_IDX_STAT);
    wire logic hit_mask = aligned && (idx == `MTS_IDX_MASK);
    wire logic hit_cmd = aligned && (idx == `MTS_IDX_CMD);
    wire logic hit_cnt = aligned && (idx == `MTS_IDX_COUNT);
    wire logic mapped = hit_len | hit_src | hit_sync | hit_stat | hit_mask | hit_cmd | hit_cnt;
    wire logic apb_setup = PSEL_I && !PENABLE_I;
    wire logic apb_done = PSEL_I && PENABLE_I;
    wire logic wr_ok = apb_done && PWRITE_I;
    wire logic stat_rd = apb_done && !PWRITE_I && hit_stat;
    wire logic soft_reset = wr_ok && hit_cmd && (PWDATA_I[7:0] == `MTS_CMD_SOFT);

    // Read mux, sampled in the setup cycle
    wire logic [31:0] rd_mux =
        hit_len ? {24'h000000, len_reg} :
        hit_src ? {24'h000000, src_reg} :
        hit_sync ? {24'h000000, sync_reg} :
        hit_stat ? {24'h000000, stat_reg} :
        hit_mask ? {24'h000000, mask_reg} :
        hit_cnt ? {8'h00, cnt_reg} : 32'h00000000;

    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_done && !mapped;
    assign PRDATA_O = prdata_reg;

    // Configuration fields
    wire logic [1:0] src = src_reg[`MTS_SRC_LO +: 2]; // RULE_03
    wire logic chk_en = src_reg[`MTS_CHK_BIT];
    wire logic [1:0] sbl = sync_reg[`MTS_SBL_LO +: 2]; // RULE_09
    wire logic lead = sync_reg[`MTS_LNT_BIT];
    wire logic gray = sync_reg[`MTS_GRAY_BIT];
    wire logic [4:0] word_len = len_decode(len_reg[`MTS_LEN_LO +: 4]); // RULE_07 RULE_08
    wire logic [4:0] sync_len = {3'h0, sbl} + 5'h01;
    wire logic [4:0] frame_bits = word_len + sync_len;
    wire logic [27:0] word_mask_full = low_mask(word_len);
    wire logic [23:0] word_mask = word_mask_full[23:0];

    // Configuration registers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            len_reg <= `MTS_REG_RST;
            src_reg <= `MTS_REG_RST;
            sync_reg <= `MTS_REG_RST;
            mask_reg <= `MTS_REG_RST;
        end else if (wr_ok) begin
            if (hit_len) len_reg <= PWDATA_I[7:0];
            if (hit_src) src_reg <= PWDATA_I[7:0];
            if (hit_sync) sync_reg <= PWDATA_I[7:0];
            if (hit_mask) mask_reg <= PWDATA_I[7:0];
        end
    end

    // Read data capture
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) prdata_reg <= 32'h00000000;
        else if (apb_setup) prdata_reg <= rd_mux;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    mts_pkg::mts_state_t state_reg;
    mts_pkg::mts_state_t state_next;
    logic [23:0] tmr_reg;
    logic [5:0] div_reg;
    logic [4:0] bit_reg;
    logic [27:0] rx_reg;
    logic [1:0] try_reg;
    logic link_clk_reg;
    logic fail_reg;
    logic checking_reg;
    logic link_fail_reg;
    logic synced_reg;
    logic [1:0] quad_prev_reg;

    wire logic serial = (src == `MTS_SRC_SER);
    wire logic parallel = (src == `MTS_SRC_PAR); // RULE_04
    wire logic div_end = (div_reg == 6'h00);
    wire logic tmr_end = (tmr_reg == 24'h000000);
    wire logic last_bit = (bit_reg + 5'h01) == frame_bits;
    wire logic sample_now = (state_reg == mts_pkg::S_FRAME) && div_end && link_clk_reg;

    // Received frame, Gray decoded then split into word and sync bits
    wire logic [27:0] rx_full = rx_reg & low_mask(frame_bits);
    wire logic [27:0] rx_bin = gray ? gray2bin(rx_full) : rx_full; // RULE_15 RULE_19
    wire logic [27:0] rx_shift = rx_bin >> sync_len;
    wire logic [23:0] ext_word = rx_shift[23:0] & word_mask;
    wire logic [3:0] sync_val = rx_bin[3:0];

    // External quadrant from the top sync bits
    wire logic [1:0] ext_quad =
        (sbl == 2'h1) ? sync_val[1:0] :
        (sbl == 2'h2) ? sync_val[2:1] :
        (sbl == 2'h3) ? sync_val[3:2] : {sync_val[0], 1'b0};

    // Alignment: multi bit uses quadrants, one bit uses lead/trail setting
    wire logic auto_up = (ST_QUAD_I == 2'h0) && (ext_quad == 2'h3); // RULE_10
    wire logic auto_dn = (ST_QUAD_I == 2'h3) && (ext_quad == 2'h0); // RULE_10
    wire logic one_up = !lead && !ST_QUAD_I[1] && sync_val[0]; // RULE_11
    wire logic one_dn = lead && ST_QUAD_I[1] && !sync_val[0]; // RULE_11
    wire logic corr_up = (sbl == 2'h0) ? one_up : auto_up; // RULE_12 RULE_16
    wire logic corr_dn = (sbl == 2'h0) ? one_dn : auto_dn; // RULE_12 RULE_16
    wire logic [23:0] load_val =
        (ext_word + (corr_up ? 24'h000001 : 24'h000000) - (corr_dn ? 24'h000001 : 24'h000000))
        & word_mask;

    // Revolution detection from singleturn quadrant wrap
    wire logic rev_fwd = (quad_prev_reg == 2'h3) && (ST_QUAD_I == 2'h0);
    wire logic rev_bwd = (quad_prev_reg == 2'h0) && (ST_QUAD_I == 2'h3);
    wire logic counting = (state_reg != mts_pkg::S_INIT) && (state_reg != mts_pkg::S_START);

    // Evaluation outcomes
    wire logic eval = (state_reg == mts_pkg::S_EVAL);
    wire logic sync_load = eval && !fail_reg && !checking_reg;
    wire logic mismatch = eval && !fail_reg && checking_reg && (load_val != cnt_reg);
    wire logic fail_final = eval && fail_reg && (checking_reg || try_reg == `MTS_LAST_TRY);
    wire logic start_fail = (state_reg == mts_pkg::S_START) && serial && !turn_link_data_pin_s;

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mts_pkg::S_INIT: begin
                state_next = (src == `MTS_SRC_INT) ? mts_pkg::S_RUN : mts_pkg::S_START;
            end
            mts_pkg::S_START: begin
                state_next = (parallel || start_fail) ? mts_pkg::S_EVAL : mts_pkg::S_FRAME;
            end
            mts_pkg::S_FRAME: begin
                if (sample_now && last_bit) state_next = mts_pkg::S_EVAL;
            end
            mts_pkg::S_EVAL: begin
                if (!fail_reg) state_next = mts_pkg::S_RUN;
                else if (checking_reg) state_next = mts_pkg::S_DEAD; // RULE_18
                else if (try_reg == `MTS_LAST_TRY) state_next = mts_pkg::S_RUN; // RULE_17
                else state_next = mts_pkg::S_PAUSE; // RULE_17
            end
            mts_pkg::S_PAUSE: begin
                if (tmr_end) state_next = mts_pkg::S_START;
            end
            mts_pkg::S_RUN: begin
                if (tmr_end && chk_en && !link_fail_reg && synced_reg) begin
                    state_next = mts_pkg::S_START; // RULE_13
                end
            end
            mts_pkg::S_DEAD: state_next = mts_pkg::S_DEAD;
            default: state_next = mts_pkg::S_INIT;
        endcase
        if (soft_reset) state_next = mts_pkg::S_INIT;
    end

    // State register
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) state_reg <= mts_pkg::S_INIT;
        else state_reg <= state_next;
    end

    // Timer for retry pause and check period
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) tmr_reg <= 24'h000000;
        else if (eval && fail_reg) tmr_reg <= 24'(RETRY_CYC - 1); // RULE_17
        else if (state_next == mts_pkg::S_RUN && state_reg != mts_pkg::S_RUN)
            tmr_reg <= 24'(CHECK_CYC - 1);
        else if (state_reg == mts_pkg::S_RUN && tmr_end) tmr_reg <= 24'(CHECK_CYC - 1); // RULE_13
        else if (!tmr_end) tmr_reg <= tmr_reg - 24'h000001;
    end

    // Link clock divider and bit counter
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            link_clk_reg <= 1'b1;
            div_reg <= 6'h00;
            bit_reg <= 5'h00;
        end else if (state_reg == mts_pkg::S_START && serial && !start_fail) begin
            link_clk_reg <= 1'b0;
            div_reg <= 6'(HALF_CYC - 1);
            bit_reg <= 5'h00;
        end else if (state_reg == mts_pkg::S_FRAME && div_end) begin
            link_clk_reg <= !link_clk_reg || last_bit;
            div_reg <= 6'(HALF_CYC - 1);
            if (link_clk_reg) bit_reg <= bit_reg + 5'h01;
        end else if (state_reg != mts_pkg::S_FRAME) begin
            link_clk_reg <= 1'b1;
        end else begin
            div_reg <= div_reg - 6'h01;
        end
    end

    // Receive shift register; sector mode takes both pins at once
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) rx_reg <= 28'h0000000;
        else if (state_reg == mts_pkg::S_START && parallel) rx_reg <= {26'h0, turn_link_clock_pin_s, turn_link_data_pin_s}; // RULE_16
        else if (state_reg == mts_pkg::S_START) rx_reg <= 28'h0000000;
        else if (sample_now) rx_reg <= {rx_reg[26:0], turn_link_data_pin_s};
    end

    // Attempt bookkeeping and permanent link error
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fail_reg <= 1'b0;
            try_reg <= 2'h0;
            checking_reg <= 1'b0;
            link_fail_reg <= 1'b0;
            synced_reg <= 1'b0;
        end else if (soft_reset) begin
            fail_reg <= 1'b0;
            try_reg <= 2'h0;
            checking_reg <= 1'b0;
            link_fail_reg <= 1'b0;
            synced_reg <= 1'b0;
        end else begin
            if (state_reg == mts_pkg::S_START) fail_reg <= start_fail;
            if (eval && fail_reg && !checking_reg) try_reg <= try_reg + 2'h1; // RULE_17
            if (state_reg == mts_pkg::S_RUN && state_next == mts_pkg::S_START) checking_reg <= 1'b1;
            if (fail_final) link_fail_reg <= 1'b1; // RULE_17 RULE_18
            if (sync_load) synced_reg <= 1'b1;
        end
    end

    // ****************************************
    // Turn counter
    // ****************************************
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_reg <= 24'h000000;
            quad_prev_reg <= 2'h0;
        end else begin
            quad_prev_reg <= ST_QUAD_I;
            if (soft_reset) cnt_reg <= 24'h000000;
            else if (sync_load) cnt_reg <= load_val; // RULE_01
            else if (counting && rev_fwd) cnt_reg <= (cnt_reg + 24'h000001) & word_mask; // RULE_02
            else if (counting && rev_bwd) cnt_reg <= (cnt_reg - 24'h000001) & word_mask; // RULE_02
        end
    end

    assign TURN_COUNT_O = cnt_reg;
    assign TURN_VALID_O = synced_reg || (src == `MTS_SRC_INT && state_reg == mts_pkg::S_RUN);
    assign TURN_LINK_CLOCK_PIN_O = link_clk_reg;
    assign TURN_LINK_CLOCK_PIN_OE_O = serial; // RULE_04

    // ****************************************
    // Status, mask and alarms
    // ****************************************
    wire logic [7:0] stat_set = {5'h00, sync_load, mismatch, link_fail_reg}; // RULE_14

    // Set wins over read clear
    always_comb begin
        stat_next = (stat_rd ? 8'h00 : stat_reg) | stat_set;
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) stat_reg <= `MTS_REG_RST;
        else stat_reg <= stat_next;
    end

    assign IRQ_O = |(stat_reg & mask_reg);
    assign ERR_N_O = !(link_fail_reg || stat_reg[`MTS_ST_CONS]); // RULE_14

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sync_load_a: assert property (sync_load |=> cnt_reg == $past(load_val)) // RULE_01
        else $error("counter not loaded after sync");
    cnt_step_a: assert property (counting && rev_fwd && !sync_load && !soft_reset && word_len == 5'h18
        |=> cnt_reg == $past(cnt_reg) + 24'h000001) // RULE_02
        else $error("counter did not advance");
    cons_flag_a: assert property (mismatch |=> stat_reg[`MTS_ST_CONS] && !ERR_N_O) // RULE_14
        else $error("mismatch not flagged");
    dead_stays_a: assert property (state_reg == mts_pkg::S_DEAD && !soft_reset
        |=> state_reg == mts_pkg::S_DEAD && link_fail_reg) // RULE_18
        else $error("readouts resumed after link error");
    no_check_a: assert property (state_reg == mts_pkg::S_RUN && !chk_en
        |=> state_reg != mts_pkg::S_START) // RULE_13
        else $error("check started while disabled");
    retry_pause_a: assert property (state_reg == mts_pkg::S_EVAL && state_next == mts_pkg::S_PAUSE
        |=> tmr_reg == 24'(RETRY_CYC - 1)) // RULE_17
        else $error("retry pause not loaded");
    lead_ignored_a: assert property (sbl != 2'h0 && $stable(sync_reg[1:0]) && $changed(lead)
        |-> corr_up == auto_up && corr_dn == auto_dn) // RULE_12
        else $error("lead select used with multi sync");
    clk_pin_dir_a: assert property (parallel |-> !TURN_LINK_CLOCK_PIN_OE_O) // RULE_04
        else $error("clock pin driven in sector mode");
    sel_len_a: assert property (len_reg[7:4] == 4'hD |-> word_len == 5'h18) // RULE_08
        else $error("length decode wrong");

    frame_c: cover property (state_reg == mts_pkg::S_FRAME ##[1:1000] sync_load);
    retry_c: cover property (state_reg == mts_pkg::S_PAUSE);
    mismatch_c: cover property (mismatch);
    dead_c: cover property (state_reg == mts_pkg::S_DEAD);

endmodule

// file: tb/mts_sensor_model.sv
// Turn sensor model: serial word source and two sector sensors
module mts_sensor_model (
    // Block pins and clock
    input wire logic clk_i,
    input wire logic link_clk_i,
    input wire logic link_oe_i,
    // Scenario controls
    input wire logic dead_i,
    input wire logic [5:0] frame_i,
    input wire logic [1:0] sector_i,
    // Lines into the block
    output logic clk_pin_o,
    output logic data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Line drivers
    // ****
    logic clk_q_reg = 1'b1;
    logic bit_reg = 1'b1;
    logic busy_reg = 1'b0;
    int idx_reg = 0;
    int hi_reg = 0;
    // Clock pin: block drives it in serial mode, else the 180 degree sensor
    assign clk_pin_o = link_oe_i ? link_clk_i : sector_i[1];
    // Data pin: dead line low, frame bit, ready level between frames
    assign data_o = dead_i ? 1'b0 : !link_oe_i ? sector_i[0] : busy_reg ? bit_reg : 1'b1;
    // New bit after each falling link clock, most significant first
    always @(posedge clk_i) begin
        clk_q_reg <= link_clk_i;
        hi_reg <= link_clk_i ? hi_reg + 1 : 0;
        if (clk_q_reg && !link_clk_i && link_oe_i) begin
            busy_reg <= 1'b1;
            bit_reg <= idx_reg < 6 ? frame_i[5 - idx_reg] : ~bit_reg;
            idx_reg <= idx_reg + 1;
        end else if (hi_reg > 70) begin
            busy_reg <= 1'b0;
            idx_reg <= 0;
        end
    end
endmodule

// file: tb/multiturn_sync_interface_test.sv
// Self-checking bench of the turn interface
`include "mts_regs.svh"
module multiturn_sync_interface_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Stimulus, pins and bookkeeping
    // ****
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] quad = 2'h0;
    logic dead = 1'b0;
    logic [5:0] frame = 6'h3F;
    logic [1:0] sector = 2'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lclk;
    logic loe;
    logic clk_pin;
    logic data_pin;
    logic [23:0] count;
    logic valid;
    logic err_n;
    logic irq;
    logic lclk_q = 1'b1;
    logic err_q;
    logic [31:0] rd;
    logic [31:0] r;
    logic [3:0] w;
    logic [1:0] q;
    logic [5:0] fb;
    logic [3:0] codes[5] = '{4'h0, 4'hC, 4'hD, 4'hE, 4'hF};
    int seed = 32'hcf02c0f6;
    int errors = 0;
    int check_count = 0;
    int falls = 0;
    int n;
    int f0;
    mts_top #(.CHECK_CYC(2000), .RETRY_CYC(50), .MAX_LEN(24)) dut_u (
        .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .ST_QUAD_I(quad), .TURN_LINK_CLOCK_PIN_I(clk_pin),
        .TURN_LINK_CLOCK_PIN_O(lclk), .TURN_LINK_CLOCK_PIN_OE_O(loe),
        .TURN_LINK_DATA_PIN_I(data_pin), .TURN_COUNT_O(count), .TURN_VALID_O(valid),
        .ERR_N_O(err_n), .IRQ_O(irq));
    mts_sensor_model sensor_u (.clk_i(clk), .link_clk_i(lclk), .link_oe_i(loe), .dead_i(dead),
        .frame_i(frame), .sector_i(sector), .clk_pin_o(clk_pin), .data_o(data_pin));
    // System clock
    always #5 clk = ~clk;
    // Count link clock pulses sent by the block
    always @(posedge clk) begin
        lclk_q <= lclk;
        if (lclk_q && !lclk && loe) falls <= falls + 1;
    end
    // ****
    // Tasks and expectations
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd & m, exp);
    endtask
    task automatic sreset();
        apb(1'b1, `MTS_IDX_CMD, `MTS_CMD_SOFT);
    endtask
    task automatic wait_for(input logic want_valid, input int lim);
        n = 0;
        while ((want_valid ? valid !== 1'b1 : err_n !== 1'b0) && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(n < lim, 1);
    endtask
    task automatic step(input logic [1:0] d, input int k);
        repeat (k) begin
            quad <= quad + d;
            repeat (3) @(posedge clk);
        end
    endtask
    function automatic logic [31:0] lmask(input logic [3:0] c);
        return (32'h1 << (c <= 4'hC ? 8 + c : c == 4'hD ? 24 : c == 4'hE ? 1 : 4)) - 32'h1;
    endfunction
    function automatic logic [31:0] sect_exp(input logic [1:0] s, input logic lt,
                                             input logic [1:0] qq);
        logic y;
        y = s[1] ^ s[0];
        return {31'h0, s[1] ^ (!lt && !qq[1] && y) ^ (lt && qq[1] && !y)};
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial begin
        #600000;
        errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        chk({loe, err_n, irq, lclk}, 4'h5);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(`MTS_IDX_SRC, 32'hFF, 32'h0);
        apb(1'b1, 8'h10, 8'hA5);
        chk(err_q, 1);
        rdchk(8'h10, 32'hFFFFFFFF, 32'h0);
        wr_mask: apb(1'b1, `MTS_IDX_MASK, 8'h03);
        foreach (codes[i]) begin
            apb(1'b1, `MTS_IDX_LEN, {codes[i], 4'h0});
            quad <= 2'h0;
            sreset();
            wait_for(1'b1, 500);
            step(2'h3, 1);
            chk(count, lmask(codes[i]));
            step(2'h1, 2);
            rdchk(`MTS_IDX_COUNT, 32'hFFFFFF, 32'h0);
        end
        apb(1'b1, `MTS_IDX_LEN, 8'hF0);
        apb(1'b1, `MTS_IDX_SRC, 8'h10);
        for (int g = 0; g < 2; g++) begin
            r = $random(seed);
            w = r[5:2];
            q = r[1:0];
            fb = {w, q};
            frame <= g ? fb ^ (fb >> 1) : fb;
            quad <= q;
            apb(1'b1, `MTS_IDX_SYNC, {4'h0, g[0], 3'h5});
            f0 = falls;
            sreset();
            wait_for(1'b1, 3000);
            chk(loe, 1);
            chk(falls - f0, 6);
            chk(count, w);
            step(2'h1, 4 - q);
            chk(count, {28'h0, w + 4'h1});
            frame <= ~frame;
            repeat (3000) @(posedge clk);
            chk(err_n, 1);
        end
        r = $random(seed);
        w = r[3:0];
        quad <= 2'h0;
        frame <= {w, 2'h0} ^ ({w, 2'h0} >> 1);
        apb(1'b1, `MTS_IDX_SRC, 8'h50);
        sreset();
        wait_for(1'b1, 3000);
        repeat (2500) @(posedge clk);
        chk(err_n, 1);
        frame <= ~frame;
        wait_for(1'b0, 3000);
        chk(irq, 1);
        rdchk(`MTS_IDX_STAT, 32'h2, 32'h2);
        chk({irq, err_n}, 2'b01);
        dead <= 1'b1;
        repeat (3000) @(posedge clk);
        rdchk(`MTS_IDX_STAT, 32'h1, 32'h1);
        dead <= 1'b0;
        f0 = falls;
        repeat (5000) @(posedge clk);
        chk({falls - f0, err_n}, 0);
        apb(1'b1, `MTS_IDX_MASK, 8'h00);
        apb(1'b1, `MTS_IDX_SRC, 8'h10);
        apb(1'b0, `MTS_IDX_STAT, 8'h00);
        dead <= 1'b1;
        sreset();
        wait_for(1'b0, 2000);
        chk(n > 100, 1);
        chk(irq, 0);
        apb(1'b1, `MTS_IDX_MASK, 8'h01);
        chk(irq, 1);
        dead <= 1'b0;
        repeat (2000) @(posedge clk);
        chk(err_n, 0);
        apb(1'b1, `MTS_IDX_LEN, 8'hE0);
        apb(1'b1, `MTS_IDX_SRC, 8'h18);
        for (int l = 0; l < 2; l++) begin
            r = $random(seed);
            sector <= r[1:0];
            q = r[3:2];
            quad <= q;
            apb(1'b1, `MTS_IDX_SYNC, {4'h0, 1'b1, l[0], 2'h0});
            sreset();
            wait_for(1'b1, 500);
            chk(loe, 0);
            chk(count, sect_exp(r[1:0], l[0], q));
        end
        finish_test();
    end
endmodule
